// ===== logic/rfcfg_pkg.sv
// constants of the rf transceiver serial configuration port
package rfcfg_pkg;

   // ******************************************************
   // word and synchroniser sizes
   // ******************************************************
   localparam int WORD_W  = 80;            // bits in one control word
   localparam int SYNC_N  = 3;             // flops on every pin input

   // slots of the pin synchroniser bank
   localparam int SY_CLK  = 0;             // serial clock seen as data
   localparam int SY_DAT  = 1;             // serial data line
   localparam int SY_PWR  = 2;             // external power-down pin
   localparam int SY_LCK  = 3;             // raw loop lock indication
   localparam int SY_LAG  = 4;             // i channel lags q channel
   localparam int SY_TXD  = 5;             // transmit data from data pin
   localparam int SY_NUM  = 6;

   // ******************************************************
   // field positions; bit pN sits at index WORD_W - N
   // ******************************************************
   localparam int SWA_ALT_LSB = 74;        // p1..p6
   localparam int SWA_RX_LSB  = 68;        // p7..p12
   localparam int MAIN_ALT_LSB = 56;       // p13..p24
   localparam int MAIN_RX_LSB = 44;        // p25..p36
   localparam int REF_ALT_LSB = 34;        // p37..p46
   localparam int REF_RX_LSB  = 24;        // p47..p56
   localparam int PA_LSB      = 20;        // p58..p60
   localparam int GAIN_IX     = 19;        // p61
   localparam int LNA_IX      = 18;        // p62
   localparam int LOCK_LSB    = 11;        // p63..p69
   localparam int PUMP_LSB    = 9;         // p70..p71
   localparam int TX_IX       = 1;         // p79
   localparam int PU_IX       = 0;         // p80

   localparam int SWA_W  = 6;
   localparam int MAIN_W = 12;
   localparam int REF_W  = 10;
   localparam int PA_W   = 3;
   localparam int LOCK_W = 7;

   // ******************************************************
   // charge pump codes and load sequencer states
   // ******************************************************
   localparam logic [1:0] PUMP_LOW  = 2'h0; // fixed 125 uA
   localparam logic [1:0] PUMP_HIGH = 2'h1; // fixed 500 uA
   localparam logic [1:0] PUMP_LOCK = 2'h2; // follows lock
   localparam logic [1:0] PUMP_MODE = 2'h3; // lock in tx, 500 uA in rx

   typedef enum logic [1:0] {
      RFCFG_IDLE  = 2'h0,                  // serial clock low
      RFCFG_ARMED = 2'h1,                  // clock high, load armed
      RFCFG_DONE  = 2'h3                   // loaded, wait clock low
   } rfcfg_ld_e;

   // ******************************************************
   // reset values
   // ******************************************************
   localparam logic [WORD_W-1:0] CTRL_RST = 80'h0; // pu bit clear
   localparam logic              PDOWN_RST = 1'h1;

endpackage : rfcfg_pkg

// ===== logic/rfcfg_port.sv
// configuration port: load control, field decode and pin logic
//
// Notes on behaviour
// - programming comes only over clock and data
// - control word holds exactly eighty bits
// - p1-p6 and p7-p12 are swallow counts
// - p13-p24 and p25-p36 are main counts
// - p37-p46 and p47-p56 are reference dividers
// - receive uses the rx divider set
// - p58-p60 pick one of eight levels
// - p61 high selects high buffer gain
// - p62 high bypasses the lna
// - p63-p69 set lock detector reference
// - pump code 00 125 uA, 01 500 uA
// - pump code 10 follows lock state
// - pump code 11: rx fixed 500 uA
// - p79 picks receive or transmit
// - p80 clear or pin low powers down
// - external pin low forces power down
// - data bit taken on clock rising edge
// - demodulated lag bit drives data pin
// - lock detector reports loop lock
// - data edge while clock high loads word
// - lock output high while loop locked
`timescale 1ns/1ns
module rfcfg_port
   import rfcfg_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_cfg_clk,
   input  wire logic              i_cfg_shift_in,
   input  wire logic              i_ext_power_down_n,
   input  wire logic              i_loop_lock,
   input  wire logic              i_iq_lag,
   input  wire logic              i_data_in,
   output logic [SWA_W-1:0]       o_swallow_count,
   output logic [MAIN_W-1:0]      o_main_count,
   output logic [REF_W-1:0]       o_ref_div,
   output logic [PA_W-1:0]        o_pa_level,
   output logic                   o_buffer_gain_high,
   output logic                   o_lna_bypass,
   output logic [LOCK_W-1:0]      o_lock_thresh,
   output logic                   o_pump_500ua,
   output logic                   o_tx_mode,
   output logic                   o_power_down,
   output logic                   o_pll_locked,
   output logic                   o_data_out,
   output logic                   o_data_oe,
   output logic                   o_tx_mod_data
);

   // ******************************************************
   // state
   // ******************************************************
   typedef struct packed {
      logic [SY_NUM-1:0][SYNC_N-1:0] syn;  // pin synchronisers
      logic [SY_NUM-1:0]      stab;        // agreed pin levels
      rfcfg_ld_e              ld_st;       // load sequencer
      logic                   load;        // word copied this cycle
      logic [WORD_W-1:0]      ctrl;        // parallel control word
      logic [SWA_W-1:0]       swallow;
      logic [MAIN_W-1:0]      main_cnt;
      logic [REF_W-1:0]       ref_div;
      logic [PA_W-1:0]        pa;
      logic                   gain;
      logic                   lna;
      logic [LOCK_W-1:0]      lock_ref;
      logic                   pump500;
      logic                   tx;
      logic                   pdown;
      logic                   locked;
      logic                   dout;
      logic                   doe;
      logic                   txmod;
   } rfcfg_port_s;

   rfcfg_port_s q;
   rfcfg_port_s d;

   logic [WORD_W-1:0] shift_word;          // link-side shift register
   logic [SY_NUM-1:0] pin_raw;             // pins before synchronising
   logic              dat_edge;            // agreed data line change
   logic              clk_high;            // agreed serial clock high
   logic              clk_low;             // agreed serial clock low
   logic              pd_now;              // power down from word/pin
   logic              tx_now;              // current direction

   // true once the second and third synchroniser stages agree
   function automatic logic agree(input logic [SYNC_N-1:0] s);
      agree = (s[1] == s[2]);
   endfunction : agree

   // ******************************************************
   // serial shift register on the link clock
   // ******************************************************
   rfcfg_shift #(
      .W              (WORD_W)
   ) u_shift (
      .i_cfg_clk      (i_cfg_clk),
      .i_cfg_shift_in (i_cfg_shift_in),
      .o_word         (shift_word)
   );

   // gather the pins that enter from outside this clock
   assign pin_raw = {i_data_in, i_iq_lag, i_loop_lock,
                     i_ext_power_down_n, i_cfg_shift_in, i_cfg_clk};

   // qualified events taken from the last two stages only
   assign dat_edge = agree(q.syn[SY_DAT])
                     && (q.syn[SY_DAT][2] != q.stab[SY_DAT]);
   assign clk_high = agree(q.syn[SY_CLK]) && q.syn[SY_CLK][2];
   assign clk_low  = agree(q.syn[SY_CLK]) && !q.syn[SY_CLK][2];
   assign tx_now   = q.ctrl[TX_IX];
   assign pd_now   = !q.ctrl[PU_IX] || !q.stab[SY_PWR];

   // ******************************************************
   // next state
   // ******************************************************
   always_comb begin
      d      = q;
      d.load = 1'h0;

      // three-stage synchronisers; level updates on agreement
      for (int k = 0; k < SY_NUM; k++) begin
         d.syn[k] = {q.syn[k][SYNC_N-2:0], pin_raw[k]};
         if (agree(q.syn[k])) begin
            d.stab[k] = q.syn[k][2];
         end
      end

      // load sequencer: one copy per clock-high phase; the word
      // is steady because the serial clock is known high, so the
      // link domain has no edge pending while it is copied
      unique case (q.ld_st)
         RFCFG_IDLE: begin
            if (clk_high) begin
               d.ld_st = RFCFG_ARMED;
            end
         end
         RFCFG_ARMED: begin
            if (clk_low) begin
               d.ld_st = RFCFG_IDLE;
            end else if (dat_edge && clk_high) begin
               d.ctrl  = shift_word;
               d.load  = 1'h1;
               d.ld_st = RFCFG_DONE;
            end
         end
         RFCFG_DONE: begin
            if (clk_low) begin
               d.ld_st = RFCFG_IDLE;
            end
         end
         default: begin
            d.ld_st = RFCFG_IDLE;
         end
      endcase

      // divider set follows the direction bit
      if (tx_now) begin
         d.swallow  = q.ctrl[SWA_ALT_LSB +: SWA_W];
         d.main_cnt = q.ctrl[MAIN_ALT_LSB +: MAIN_W];
         d.ref_div  = q.ctrl[REF_ALT_LSB +: REF_W];
      end else begin
         d.swallow  = q.ctrl[SWA_RX_LSB +: SWA_W];
         d.main_cnt = q.ctrl[MAIN_RX_LSB +: MAIN_W];
         d.ref_div  = q.ctrl[REF_RX_LSB +: REF_W];
      end

      // analog settings passed straight from the word
      d.pa       = q.ctrl[PA_LSB +: PA_W];
      d.gain     = q.ctrl[GAIN_IX];
      d.lna      = q.ctrl[LNA_IX];
      d.lock_ref = q.ctrl[LOCK_LSB +: LOCK_W];
      d.tx       = tx_now;

      // charge pump current policy
      unique case (q.ctrl[PUMP_LSB +: 2])
         PUMP_LOW:  d.pump500 = 1'h0;
         PUMP_HIGH: d.pump500 = 1'h1;
         PUMP_LOCK: d.pump500 = !q.stab[SY_LCK];
         PUMP_MODE: d.pump500 = !tx_now || !q.stab[SY_LCK];
      endcase

      // power and lock status
      d.pdown  = pd_now;
      d.locked = q.stab[SY_LCK];

      // data pin: demodulator drives it in receive only
      d.doe   = !tx_now && !pd_now;
      d.dout  = d.doe && q.stab[SY_LAG];
      d.txmod = tx_now && !pd_now && q.stab[SY_TXD];
   end

   // ******************************************************
   // registers
   // ******************************************************
   // reset clears the word, which leaves the part powered down
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         q       <= '0;
         q.ctrl  <= CTRL_RST;
         q.pdown <= PDOWN_RST;
      end else begin
         q <= d;
      end
   end

   // ******************************************************
   // outputs
   // ******************************************************
   assign o_swallow_count    = q.swallow;
   assign o_main_count       = q.main_cnt;
   assign o_ref_div          = q.ref_div;
   assign o_pa_level         = q.pa;
   assign o_buffer_gain_high = q.gain;
   assign o_lna_bypass       = q.lna;
   assign o_lock_thresh      = q.lock_ref;
   assign o_pump_500ua       = q.pump500;
   assign o_tx_mode          = q.tx;
   assign o_power_down       = q.pdown;
   assign o_pll_locked       = q.locked;
   assign o_data_out         = q.dout;
   assign o_data_oe          = q.doe;
   assign o_tx_mod_data      = q.txmod;

   // ******************************************************
   // checks
   // ******************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   sequence s_armed_edge;
      (q.ld_st == RFCFG_ARMED) && dat_edge && clk_high;
   endsequence

   sequence s_copied;
      q.load && (q.ctrl == $past(shift_word));
   endsequence

   AST_LOAD_COPY:
   assert property (s_armed_edge |=> s_copied)
   else $error("data edge with clock high did not load word");

   AST_LOAD_ONCE:
   assert property (q.load |=> !q.load [*3])
   else $error("word loaded twice in one clock high phase");

   AST_WORD_HOLD:
   assert property (!q.load |-> $stable(q.ctrl))
   else $error("control word changed without a load");

   AST_RX_DIV:
   assert property (!q.ctrl[TX_IX] ##1 $stable(q.ctrl) |->
      o_main_count == q.ctrl[MAIN_RX_LSB +: MAIN_W]
      && o_ref_div == q.ctrl[REF_RX_LSB +: REF_W]
      && o_swallow_count == q.ctrl[SWA_RX_LSB +: SWA_W])
   else $error("receive mode not using rx divider set");

   AST_TX_DIV:
   assert property (q.ctrl[TX_IX] ##1 $stable(q.ctrl) |->
      o_main_count == q.ctrl[MAIN_ALT_LSB +: MAIN_W]
      && o_ref_div == q.ctrl[REF_ALT_LSB +: REF_W]
      && o_swallow_count == q.ctrl[SWA_ALT_LSB +: SWA_W])
   else $error("transmit mode not using alternate divider set");

   AST_PU_BIT:
   assert property (!q.ctrl[PU_IX] |=> o_power_down)
   else $error("power-up bit clear but not powered down");

   AST_EXT_PIN:
   assert property (!q.stab[SY_PWR] |=> o_power_down && !o_data_oe)
   else $error("external pin low but not powered down");

   AST_PUMP_FIX:
   assert property (q.ctrl[PUMP_LSB +: 2] == PUMP_LOW
      |=> !o_pump_500ua)
   else $error("pump code 00 not at 125 uA");

   AST_PUMP_LCK:
   assert property (q.ctrl[PUMP_LSB +: 2] == PUMP_LOCK
      |=> o_pump_500ua == !$past(q.stab[SY_LCK]))
   else $error("pump code 10 not following lock");

   AST_PUMP_RX:
   assert property (q.ctrl[PUMP_LSB +: 2] == PUMP_MODE
      && !q.ctrl[TX_IX] |=> o_pump_500ua)
   else $error("pump code 11 in receive not at 500 uA");

   AST_LOCK_OUT:
   assert property (i_loop_lock [*6] |=> o_pll_locked)
   else $error("lock output low while loop held locked");

   AST_DEMOD:
   assert property (!q.ctrl[TX_IX] && !pd_now |=>
      o_data_oe && o_data_out == $past(q.stab[SY_LAG]))
   else $error("demodulated bit not on data pin in receive");

   sequence s_done_hold;
      (q.ld_st == RFCFG_DONE) && !clk_low;
   endsequence

   AST_DONE_ONCE:
   assert property (s_done_hold |=> !q.load)
   else $error("second data edge in one clock high phase loaded");

   AST_FIELDS:
   assert property (1'h1 |=> o_pa_level == $past(q.ctrl[PA_LSB +: PA_W])
      && o_buffer_gain_high == $past(q.ctrl[GAIN_IX])
      && o_lna_bypass == $past(q.ctrl[LNA_IX]))
   else $error("amplifier settings differ from the control word");

   AST_LOCK_REF:
   assert property (1'h1 |=>
      o_lock_thresh == $past(q.ctrl[LOCK_LSB +: LOCK_W]))
   else $error("lock reference differs from the control word");

   AST_DIRECTION:
   assert property (1'h1 |=> o_tx_mode == $past(q.ctrl[TX_IX]))
   else $error("direction output differs from the control word");

   AST_PUMP_HI:
   assert property (q.ctrl[PUMP_LSB +: 2] == PUMP_HIGH |=> o_pump_500ua)
   else $error("pump code 01 not at 500 uA");

   AST_PUMP_TX:
   assert property (q.ctrl[PUMP_LSB +: 2] == PUMP_MODE && q.ctrl[TX_IX]
      |=> o_pump_500ua == !$past(q.stab[SY_LCK]))
   else $error("pump code 11 in transmit not following lock");

   sequence s_powered;
      q.ctrl[PU_IX] && q.stab[SY_PWR];
   endsequence

   AST_PU_ON:
   assert property (s_powered |=> !o_power_down)
   else $error("powered up with pin high but still powered down");

   AST_LOCK_LOW:
   assert property (!i_loop_lock [*6] |=> !o_pll_locked)
   else $error("lock output high while loop held unlocked");

   AST_TX_QUIET:
   assert property (q.ctrl[TX_IX] |=> !o_data_oe && !o_data_out)
   else $error("data pin driven in transmit mode");

endmodule : rfcfg_port

// ===== logic/rfcfg_shift.sv
// serial shift register running on the host serial clock
`timescale 1ns/1ns
module rfcfg_shift
   import rfcfg_pkg::*;
#(
   parameter int W = WORD_W
) (
   input  wire logic         i_cfg_clk,
   input  wire logic         i_cfg_shift_in,
   output logic [W-1:0]      o_word
);

   typedef struct packed {
      logic [W-1:0] sreg;
   } rfcfg_shift_s;

   rfcfg_shift_s q;
   rfcfg_shift_s d;

   // ******************************************************
   // shifting
   // ******************************************************
   // first bit in ends at the top, so p1 lands at index W-1
   always_comb begin
      d      = q;
      d.sreg = {q.sreg[W-2:0], i_cfg_shift_in};
   end

   // the serial clock may stop; no reset lives in this domain
   always_ff @(posedge i_cfg_clk) begin
      q <= d;
   end

   assign o_word = q.sreg;

   // ******************************************************
   // checks
   // ******************************************************
   // no reset here, so bits are followed one at a time once known
   AST_SHIFT_EDGE:
   assert property (@(posedge i_cfg_clk) i_cfg_shift_in |=> q.sreg[0])
   else $error("shift register did not take a one bit");

   AST_SHIFT_ZERO:
   assert property (@(posedge i_cfg_clk) !i_cfg_shift_in |=> !q.sreg[0])
   else $error("shift register did not take a zero bit");

   AST_SHIFT_TOP:
   assert property (@(posedge i_cfg_clk) q.sreg[W-2] |=> q.sreg[W-1])
   else $error("shift register did not move its bits up");

endmodule : rfcfg_shift

// ===== testbench/rfcfg_host_model.sv
// host model driving the serial configuration link and power-down pin
`timescale 1ns/1ns
module rfcfg_host_model (
   output logic o_cfg_clk,
   output logic o_cfg_shift_in,
   output logic o_ext_power_down_n
);
   // link clock stands still between frames; pin low before first load
   initial begin
      o_cfg_clk          = 1'h0;
      o_cfg_shift_in     = 1'h0;
      o_ext_power_down_n = 1'h0;
   end

   // junk bits first, then the word msb first, then an optional load
   task automatic send_word(input logic [79:0] w, input int junk,
                            input bit load);
      logic [79:0] sr;
      sr = w;
      for (int i = 0; i < junk + 80; i++) begin
         o_cfg_shift_in = (i < junk) ? i[0] : sr[79];
         if (i >= junk)
            sr = {sr[78:0], 1'h0};
         #7;
         o_cfg_clk = 1'h1; // bit already set up before the edge
         #8;
         o_cfg_clk = 1'h0; // data moves only while clock low
      end
      // toggle data in a long clock-high phase to load the word
      if (load) begin
         o_cfg_clk = 1'h1;
         #40;
         o_cfg_shift_in = !o_cfg_shift_in;
         #20;
         // a second edge in the same high phase must be ignored
         if (junk == 3)
            o_cfg_shift_in = !o_cfg_shift_in;
         #20;
         o_cfg_clk = 1'h0;
      end
   endtask : send_word

   // external power-down pin level
   task automatic set_pd(input logic v);
      o_ext_power_down_n = v;
   endtask : set_pd
endmodule : rfcfg_host_model

// ===== testbench/rfcfg_port_tb_top.sv
// self-checking testbench of the configuration port
`timescale 1ns/1ns
module rfcfg_port_tb_top
   import rfcfg_pkg::*;
;
   logic              i_clk;
   logic              i_resetn;
   logic              cfg_clk;
   logic              cfg_dat;
   logic              pwr_n;
   logic              loop_lock;
   logic              iq_lag;
   logic              host_txd;
   wire               pin_lvl;
   logic [SWA_W-1:0]  swc;
   logic [MAIN_W-1:0] mnc;
   logic [REF_W-1:0]  rfd;
   logic [PA_W-1:0]   pal;
   logic              gain;
   logic              lnab;
   logic [LOCK_W-1:0] lkt;
   logic              p500;
   logic              txm;
   logic              pdn;
   logic              pll;
   logic              dout;
   logic              doe;
   logic              tmd;
   logic [15:0]       lfsr_q;
   logic [79:0]       w;
   int                failures;
   int                comparisons;

   // data pin level from whoever drives it
   assign pin_lvl = doe ? dout : host_txd;

   rfcfg_host_model host (
      .o_cfg_clk          (cfg_clk),
      .o_cfg_shift_in     (cfg_dat),
      .o_ext_power_down_n (pwr_n)
   );

   rfcfg_port DUT (
      .i_clk              (i_clk),
      .i_resetn           (i_resetn),
      .i_cfg_clk          (cfg_clk),
      .i_cfg_shift_in     (cfg_dat),
      .i_ext_power_down_n (pwr_n),
      .i_loop_lock        (loop_lock),
      .i_iq_lag           (iq_lag),
      .i_data_in          (pin_lvl),
      .o_swallow_count    (swc),
      .o_main_count       (mnc),
      .o_ref_div          (rfd),
      .o_pa_level         (pal),
      .o_buffer_gain_high (gain),
      .o_lna_bypass       (lnab),
      .o_lock_thresh      (lkt),
      .o_pump_500ua       (p500),
      .o_tx_mode          (txm),
      .o_power_down       (pdn),
      .o_pll_locked       (pll),
      .o_data_out         (dout),
      .o_data_oe          (doe),
      .o_tx_mod_data      (tmd)
   );

   // ********************************************************
   // helpers
   // ********************************************************
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // divider set in use for the selected direction
   function automatic logic [27:0] act_set(input logic [79:0] v);
      if (v[TX_IX])
         return {v[SWA_ALT_LSB+:SWA_W], v[MAIN_ALT_LSB+:MAIN_W],
                 v[REF_ALT_LSB+:REF_W]};
      return {v[SWA_RX_LSB+:SWA_W], v[MAIN_RX_LSB+:MAIN_W],
              v[REF_RX_LSB+:REF_W]};
   endfunction : act_set

   // high pump current expected for a code, direction and lock
   function automatic logic exp_pump(input logic [1:0] c, input logic tx,
                                     input logic lk);
      case (c)
         PUMP_LOW:  return 1'h0;
         PUMP_HIGH: return 1'h1;
         PUMP_LOCK: return !lk;
         default:   return tx ? !lk : 1'h1;
      endcase
   endfunction : exp_pump

   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic settle();
      repeat (12) @(posedge i_clk);
      #1;
   endtask : settle

   // all outputs against the loaded word and the pin levels
   task automatic check_all(input logic [79:0] v);
      logic tx;
      logic pd;
      logic oe;
      tx = v[TX_IX];
      pd = !v[PU_IX] || !pwr_n;
      oe = !tx && !pd;
      chk({swc, mnc, rfd}, act_set(v));
      chk(pal, v[PA_LSB+:PA_W]);
      chk(gain, v[GAIN_IX]);
      chk(lnab, v[LNA_IX]);
      chk(lkt, v[LOCK_LSB+:LOCK_W]);
      chk(p500, exp_pump(v[PUMP_LSB+:2], tx, loop_lock));
      chk(txm, tx);
      chk(pdn, pd);
      chk(pll, loop_lock);
      chk({doe, dout}, {oe, oe & iq_lag});
      chk(tmd, tx & !pd & host_txd);
   endtask : check_all

   // everything low except power-down
   task automatic chk_reset();
      chk(pdn, 1'h1);
      chk({swc, mnc, rfd, pal, gain, lnab, lkt, p500, txm, pll, dout, doe,
           tmd}, 80'h0);
   endtask : chk_reset

   task automatic wrap_up();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // ********************************************************
   // clock, watchdog and main sequence
   // ********************************************************
   initial begin
      i_clk = 1'h0;
      forever #2 i_clk = ~i_clk;
   end

   initial begin
      repeat (60000) @(posedge i_clk);
      failures++;
      wrap_up();
   end

   initial begin
      i_resetn    = 1'h0;
      loop_lock   = 1'h0;
      iq_lag      = 1'h0;
      host_txd    = 1'h0;
      lfsr_q      = 16'h001E;
      failures    = 0;
      comparisons = 0;
      repeat (3) @(posedge i_clk);
      #1;
      i_resetn = 1'h1;
      chk_reset();
      for (int i = 0; i < 16; i++) begin
         for (int k = 0; k < 5; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            w = {w[63:0], lfsr_q};
         end
         w[23] = 1'h0;
         w[8] = 1'h1;
         w[7:2] = 6'h00;
         w[PUMP_LSB+:2] = i[1:0];
         w[TX_IX] = i[2];
         w[PA_LSB+:PA_W] = i[2:0];
         w[PU_IX] = (i % 7 != 6);
         if (i < 2)
            w[LOCK_LSB+:LOCK_W] = {7{i[0]}};
         // extra leading bits: only the last eighty count
         host.send_word(w, i % 4, 1'h1);
         settle();
         check_all(w);
         // pins move without a reload
         @(posedge i_clk);
         #1;
         host.set_pd(i != 9);
         loop_lock = ~loop_lock;
         iq_lag = lfsr_q[3];
         host_txd = lfsr_q[7];
         settle();
         check_all(w);
         // a word shifted without a load leaves outputs alone
         if (i == 5) begin
            host.send_word(~w, 0, 1'h0);
            settle();
            check_all(w);
         end
      end
      // second reset in mid-run
      @(posedge i_clk);
      #1;
      i_resetn = 1'h0;
      repeat (3) @(posedge i_clk);
      #1;
      chk_reset();
      i_resetn = 1'h1;
      // the first edges after release still show the idle word
      repeat (2) @(posedge i_clk);
      #1;
      chk_reset();
      wrap_up();
   end
endmodule : rfcfg_port_tb_top
